// File: verilog/light_timing_pkg.sv
package light_timing_pkg;
	// Clock and oscillator rates
	localparam int CLK_KHZ = 125000;
	localparam int OSC_FULL_KHZ = 655;
	// Full-speed oscillator period in CLK cycles; half speed doubles it
	localparam int OSC_DIV = CLK_KHZ / OSC_FULL_KHZ;
	localparam int DIV_W = 10;
	localparam logic [DIV_W-1:0] OSC_DIV_CYC = DIV_W'(OSC_DIV);

	// Width field codes and cycles per conversion
	localparam logic [1:0] WIDTH_16 = 2'h0;
	localparam logic [1:0] WIDTH_12 = 2'h1;
	localparam logic [1:0] WIDTH_8 = 2'h2;
	localparam logic [1:0] WIDTH_4 = 2'h3;
	localparam logic [16:0] CYC_16 = 17'h10000;
	localparam logic [16:0] CYC_12 = 17'h01000;
	localparam logic [16:0] CYC_8 = 17'h00100;
	localparam logic [16:0] CYC_4 = 17'h00010;

	// Field positions in the command and control registers
	localparam int CMD_WIDTH_LSB = 0;
	localparam int CMD_TIMING_BIT = 5;
	localparam int CTL_RANGE_LSB = 2;

	// Range constants for k = 1..4
	localparam logic [15:0] RANGE_K1 = 16'h03CD;
	localparam logic [15:0] RANGE_K2 = 16'h0F34;
	localparam logic [15:0] RANGE_K3 = 16'h3CD0;
	localparam logic [15:0] RANGE_K4 = 16'hF340;

	// Values after reset, and the external timer limit
	localparam logic [1:0] RST_WIDTH = 2'h0;
	localparam logic [1:0] RST_RANGE = 2'h0;
	localparam logic [16:0] RST_COUNT = 17'h00000;
	localparam logic [15:0] RST_TIMER = 16'h0000;
	localparam logic [15:0] TIMER_MAX = 16'hFFFF;
endpackage : light_timing_pkg

// File: verilog/osc_tick_gen.sv
`timescale 1ns/1ps
// Oscillator stand-in: one tick per oscillator period, built from CLK
module osc_tick_gen #(
	parameter logic [light_timing_pkg::DIV_W-1:0] DIV = light_timing_pkg::OSC_DIV_CYC
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic half,
	output logic tick
);
	logic [light_timing_pkg::DIV_W:0] cnt;
	logic [light_timing_pkg::DIV_W:0] next_cnt;
	logic [light_timing_pkg::DIV_W:0] limit;
	logic next_tick;

	always_comb begin
		// Half speed doubles the period rather than skipping ticks
		limit = half ? {DIV, 1'b0} : {1'b0, DIV};
		next_tick = 1'b0;
		next_cnt = cnt + 1'b1;
		if (cnt >= limit - 1'b1) begin
			next_cnt = '0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule : osc_tick_gen

// File: verilog/light_adc_timing.sv
`timescale 1ns/1ps
// How it works
// RULE1: Internal mode ends after exactly 2^n ticks
// RULE2: Timing bit picks internal or external mode
// RULE3: Ranges 1 and 2 halve oscillator speed
// RULE4: Range field selects one of four constants
// RULE5: Internal count unsigned, at most 2^n
// RULE6: External mode publishes elapsed ticks as full scale
// RULE7: Width codes give 65536, 4096, 256, 16
// RULE8: Range codes 00..11 map to k 1..4
// RULE9: Each sync ends integration, starts next
// RULE10: Sixteen-bit tick counter; host avoids overflow
// RULE11: New settings apply at next conversion start; code drops an external conversion at once when TIMING_EXT clears
module light_adc_timing (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [1:0] WIDTH,
	input wire logic TIMING_EXT,
	input wire logic [1:0] RANGE,
	input wire logic SYNC,
	input wire logic LIGHT,
	output logic [16:0] DATA,
	output logic [15:0] COUNTER,
	output logic [16:0] FULL_SCALE,
	output logic [15:0] RANGE_CONST,
	output logic DONE,
	output logic BUSY,
	output logic OSC_HALF
);
	typedef enum logic {IDLE, RUN} state_e;

	function automatic logic [16:0] full_of(input logic [1:0] w);
		unique case (w)
			light_timing_pkg::WIDTH_16: full_of = light_timing_pkg::CYC_16;
			light_timing_pkg::WIDTH_12: full_of = light_timing_pkg::CYC_12;
			light_timing_pkg::WIDTH_8: full_of = light_timing_pkg::CYC_8;
			light_timing_pkg::WIDTH_4: full_of = light_timing_pkg::CYC_4;
		endcase
	endfunction : full_of

	function automatic logic [15:0] range_of(input logic [1:0] k);
		unique case (k)
			2'h0: range_of = light_timing_pkg::RANGE_K1;
			2'h1: range_of = light_timing_pkg::RANGE_K2;
			2'h2: range_of = light_timing_pkg::RANGE_K3;
			2'h3: range_of = light_timing_pkg::RANGE_K4;
		endcase
	endfunction : range_of

	// Light pulses come from the analog front end, outside this clock
	logic light_m;
	logic light_s;
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			light_m <= 1'b0;
			light_s <= 1'b0;
		end else begin
			light_m <= LIGHT;
			light_s <= light_m;
		end
	end

	state_e state, next_state;
	logic [1:0] cfg_width, next_cfg_width;
	logic [1:0] cfg_k, next_cfg_k;
	logic cfg_ext, next_cfg_ext;
	logic [16:0] cyc, next_cyc;
	logic [16:0] acc, next_acc;
	logic [16:0] next_data, next_full;
	logic [15:0] next_counter;
	logic next_done;
	logic start_evt, end_int, end_ext, inc, tick, osc_half;
	logic [16:0] full;
	logic [16:0] cap;

	// Oscillator speed follows cfg_k while a conversion runs and the RANGE input while idle
	assign osc_half = (state == RUN) ? !cfg_k[1] : !RANGE[1]; // RULE3

	osc_tick_gen #(.DIV(light_timing_pkg::OSC_DIV_CYC)) u_osc (
		.CLK(CLK),
		.NRST(NRST),
		.half(osc_half),
		.tick(tick)
	);

	always_comb begin
		full = full_of(cfg_width); // RULE7
		// External counts are bounded by the timer, not by 2^n
		cap = cfg_ext ? {1'b0, light_timing_pkg::TIMER_MAX} : full; // RULE6
		inc = (state == RUN) && tick && light_s;
		end_int = (state == RUN) && !cfg_ext && tick && (cyc == full - 17'h1); // RULE1
		end_ext = (state == RUN) && cfg_ext && SYNC; // RULE9
		start_evt = 1'b0;
		next_state = state;
		next_cfg_width = cfg_width;
		next_cfg_k = cfg_k;
		next_cfg_ext = cfg_ext;
		next_cyc = cyc;
		next_acc = acc;
		next_data = DATA;
		next_full = FULL_SCALE;
		next_counter = COUNTER;
		next_done = 1'b0;
		if (state == RUN && tick) begin
			// External count wraps at 16 bits; the host keeps integrations short
			next_cyc = cfg_ext ? {1'b0, cyc[15:0] + 16'h1} : cyc + 17'h1; // RULE10
			if (light_s && acc < cap) begin
				next_acc = acc + 17'h1; // RULE5
			end
		end
		if (end_int || end_ext) begin
			next_done = 1'b1;
			next_data = (inc && acc < cap) ? acc + 17'h1 : acc;
			if (cfg_ext) begin
				// Closing tick counts in both, so DATA never exceeds COUNTER
				next_counter = next_cyc[15:0]; // RULE6
				next_full = {1'b0, next_cyc[15:0]}; // RULE6
			end else begin
				next_full = full; // RULE5
			end
			next_state = IDLE;
		end else if (state == RUN && cfg_ext && !TIMING_EXT) begin
			// Leaving external mode drops the open integration
			next_state = IDLE;
		end
		// Internal mode restarts at once; external waits for a sync
		if (((state == IDLE || end_int) && !TIMING_EXT) || (TIMING_EXT && SYNC)) begin // RULE2
			start_evt = (state == IDLE) || end_int || end_ext;
		end
		if (start_evt) begin
			next_state = RUN;
			next_cfg_width = WIDTH; // RULE11
			next_cfg_k = RANGE; // RULE8
			next_cfg_ext = TIMING_EXT; // RULE2
			next_cyc = light_timing_pkg::RST_COUNT;
			next_acc = light_timing_pkg::RST_COUNT;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			state <= IDLE;
			cfg_width <= light_timing_pkg::RST_WIDTH;
			cfg_k <= light_timing_pkg::RST_RANGE;
			cfg_ext <= 1'b0;
			cyc <= light_timing_pkg::RST_COUNT;
			acc <= light_timing_pkg::RST_COUNT;
			DATA <= light_timing_pkg::RST_COUNT;
			FULL_SCALE <= light_timing_pkg::RST_COUNT;
			COUNTER <= light_timing_pkg::RST_TIMER;
			RANGE_CONST <= light_timing_pkg::RANGE_K1;
			DONE <= 1'b0;
			BUSY <= 1'b0;
			OSC_HALF <= 1'b1;
		end else begin
			state <= next_state;
			cfg_width <= next_cfg_width;
			cfg_k <= next_cfg_k;
			cfg_ext <= next_cfg_ext;
			cyc <= next_cyc;
			acc <= next_acc;
			DATA <= next_data;
			FULL_SCALE <= next_full;
			COUNTER <= next_counter;
			RANGE_CONST <= range_of(next_cfg_k); // RULE4
			DONE <= next_done;
			BUSY <= (next_state == RUN);
			OSC_HALF <= !next_cfg_k[1]; // RULE3
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	property p_int_len;
		end_int |=> DONE && FULL_SCALE == $past(full);
	endproperty
	a_int_len: assert property (p_int_len) else $error("internal length wrong"); // RULE1

	property p_mode;
		(NRST && state == IDLE && !TIMING_EXT) |=> state == RUN && !cfg_ext;
	endproperty
	a_mode: assert property (p_mode) else $error("internal mode did not start"); // RULE2

	property p_half;
		state == RUN |-> OSC_HALF == !cfg_k[1] && osc_half == OSC_HALF;
	endproperty
	a_half: assert property (p_half) else $error("oscillator speed wrong"); // RULE3

	property p_range;
		$changed(cfg_k) |-> RANGE_CONST == range_of(cfg_k);
	endproperty
	a_range: assert property (p_range) else $error("range constant wrong"); // RULE4

	property p_data_max;
		DONE |-> DATA <= FULL_SCALE;
	endproperty
	a_data_max: assert property (p_data_max) else $error("count above full scale"); // RULE5

	property p_ext_cnt;
		end_ext |=> DONE && COUNTER == $past(cyc[15:0]) + {15'h0, $past(tick)}
			&& FULL_SCALE == {1'b0, COUNTER};
	endproperty
	a_ext_cnt: assert property (p_ext_cnt) else $error("timer not published"); // RULE6

	property p_enc;
		state == RUN && !cfg_ext |-> (cfg_width == 2'h0 && full == 17'h10000)
			|| (cfg_width == 2'h1 && full == 17'h01000)
			|| (cfg_width == 2'h2 && full == 17'h00100)
			|| (cfg_width == 2'h3 && full == 17'h00010);
	endproperty
	a_enc: assert property (p_enc) else $error("width encoding wrong"); // RULE7

	property p_k4;
		state == RUN && cfg_k == 2'h3 |-> RANGE_CONST == 16'hF340 && !OSC_HALF;
	endproperty
	a_k4: assert property (p_k4) else $error("range code mapping wrong"); // RULE8

	property p_sync;
		end_ext && TIMING_EXT |=> state == RUN && cyc == 17'h0 && acc == 17'h0;
	endproperty
	a_sync: assert property (p_sync) else $error("sync did not restart"); // RULE9

	property p_wrap;
		state == RUN && cfg_ext && tick && !SYNC && TIMING_EXT
			|=> !cyc[16] && cyc[15:0] == $past(cyc[15:0]) + 16'h1;
	endproperty
	a_wrap: assert property (p_wrap) else $error("timer not sixteen bits"); // RULE10

	property p_hold;
		state == RUN && !start_evt |=> $stable(cfg_width) && $stable(cfg_k);
	endproperty
	a_hold: assert property (p_hold) else $error("settings changed mid conversion"); // RULE11

	c_int: cover property (end_int ##1 DONE);
	c_ext: cover property (end_ext ##[1:1000] end_ext);
	c_half: cover property (state == RUN && OSC_HALF && end_int);
endmodule : light_adc_timing

// File: testbench/light_host_model.sv
`timescale 1ns/1ps
// Host stand-in: sync commands as one-cycle pulses on the shared clock
module light_host_model (
	input wire logic clk,
	output logic sync
);
	initial sync = 1'b0;
	// Each pulse ends the running integration and starts the next
	task send_sync;
		@(posedge clk);
		sync <= 1'b1;
		@(posedge clk);
		sync <= 1'b0;
	endtask : send_sync
	// Callers keep gaps far below the 16-bit tick limit, so no wrap
endmodule : light_host_model

// File: testbench/test_light_adc_integration_timing.sv
`timescale 1ns/1ps
module test_light_adc_integration_timing;
	logic CLK, NRST, TIMING_EXT, LIGHT, SYNC, DONE, BUSY, OSC_HALF, lt;
	logic [1:0] WIDTH, RANGE, prev;
	logic [16:0] DATA, FULL_SCALE;
	logic [15:0] COUNTER, RANGE_CONST;
	int n_mismatch, check_count, seed, cyc, g, t;

	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end

	light_adc_timing i_dut (.CLK(CLK), .NRST(NRST), .WIDTH(WIDTH), .TIMING_EXT(TIMING_EXT),
		.RANGE(RANGE), .SYNC(SYNC), .LIGHT(LIGHT), .DATA(DATA), .COUNTER(COUNTER),
		.FULL_SCALE(FULL_SCALE), .RANGE_CONST(RANGE_CONST), .DONE(DONE), .BUSY(BUSY),
		.OSC_HALF(OSC_HALF));
	light_host_model i_host (.clk(CLK), .sync(SYNC));

	task complete_run;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	task chk_val(input logic [16:0] got, input logic [16:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task chk_cyc(input int got, input int exp);
		check_count++;
		if (got != exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_cyc

	// Counts edges up to and including the one where DONE is seen
	task wait_done(output int c, input int lim);
		c = 0;
		do begin
			@(posedge CLK);
			c++;
			if (c > lim) begin
				n_mismatch++;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, c, lim);
				complete_run;
			end
		end while (DONE !== 1'b1);
	endtask : wait_done

	function automatic int per(input logic [1:0] w, input logic [1:0] r);
		return (1 << (16 - 4 * w)) * light_timing_pkg::OSC_DIV * ((r < 2'h2) ? 2 : 1);
	endfunction : per

	function automatic logic [15:0] kconst(input logic [1:0] r);
		case (r)
			2'h0: return 16'h03CD;
			2'h1: return 16'h0F34;
			2'h2: return 16'h3CD0;
			default: return 16'hF340;
		endcase
	endfunction : kconst

	// Widths 00 and 01 run at least 778240 cycles, so only 10 and 11 are timed
	initial begin
		seed = 32'hee9c;
		n_mismatch = 0;
		check_count = 0;
		NRST = 1'b0;
		WIDTH = 2'h3;
		RANGE = 2'h3;
		TIMING_EXT = 1'b0;
		LIGHT = 1'b1;
		repeat (8) @(posedge CLK);
		NRST <= 1'b1;
		wait_done(cyc, 8000);
		prev = 2'h3;
		lt = 1'b1;
		for (int r = 0; r < 4; r++) begin
			lt = 1'($random(seed));
			RANGE <= 2'(r);
			LIGHT <= lt;
			wait_done(cyc, 8000);
			chk_cyc(cyc, per(2'h3, prev));
			chk_val(17'(RANGE_CONST), 17'(kconst(2'(r))));
			wait_done(cyc, 8000);
			chk_cyc(cyc, per(2'h3, 2'(r)));
			chk_val(17'(OSC_HALF), 17'(r < 2));
			chk_val(17'(RANGE_CONST), 17'(kconst(2'(r))));
			chk_val(DATA, lt ? 17'h00010 : 17'h00000);
			chk_val(FULL_SCALE, 17'h00010);
			prev = 2'(r);
		end
		WIDTH <= 2'h2;
		wait_done(cyc, 8000);
		chk_cyc(cyc, per(2'h3, 2'h3));
		TIMING_EXT <= 1'b1;
		WIDTH <= 2'h3;
		wait_done(cyc, 60000);
		chk_cyc(cyc, per(2'h2, 2'h3));
		chk_val(FULL_SCALE, 17'h00100);
		chk_val(DATA, lt ? 17'h00100 : 17'h00000);
		// Steady light: every tick counts, so DATA must equal COUNTER
		LIGHT <= 1'b1;
		i_host.send_sync();
		for (int i = 0; i < 2; i++) begin
			g = 500 + int'($unsigned($random(seed)) % 400);
			t = (g + 1) / light_timing_pkg::OSC_DIV;
			repeat (g) @(posedge CLK);
			i_host.send_sync();
			wait_done(cyc, 4);
			chk_cyc(cyc, 1);
			chk_val(17'(COUNTER + 1 >= t && COUNTER <= t + 1), 17'h00001);
			chk_val(FULL_SCALE, 17'(COUNTER));
			chk_val(DATA, 17'(COUNTER));
			chk_val(17'(BUSY), 17'h00001);
		end
		// Reset in mid conversion must restore DATA, COUNTER, RANGE_CONST, OSC_HALF and BUSY
		NRST <= 1'b0;
		repeat (2) @(posedge CLK);
		chk_val(DATA, 17'h00000);
		chk_val(17'(COUNTER), 17'h00000);
		chk_val(17'(RANGE_CONST), 17'h003CD);
		chk_val(17'(OSC_HALF), 17'h00001);
		chk_val(17'(BUSY), 17'h00000);
		complete_run;
	end
endmodule : test_light_adc_integration_timing
